// [include/clock_gear_pkg.sv]
package clock_gear_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SYS_CTRL_FIRST = 8'h00;
  localparam logic [7:0] OFS_SYS_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // First control register fields
  localparam int STOP_RET_BIT = 0;
  localparam int CMD_LSB = 2;
  localparam int DUAL_CLK_BIT = 4;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_SLEEP = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  // Second control register fields
  localparam int GEAR_LSB = 0;
  localparam int SYSCLK_SOURCE_SELECT_BIT = 2;
  localparam int OSC_INPUT_DIVIDE_BIT_BIT = 3;
  localparam logic [1:0] GEAR_DIV2 = 2'h0;
  localparam logic [1:0] GEAR_DIV4 = 2'h1;
  localparam logic [1:0] GEAR_DIV8 = 2'h2;
  localparam logic [1:0] GEAR_RESET = GEAR_DIV8;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  // Oscillator-to-PLL ratio
  localparam logic [1:0] PLL_LAST = 2'h3;
  // Fixed reset vector
  localparam logic [31:0] RESET_VECTOR = 32'hBFC0_0000;
  // Reset filter timing
  localparam int CLK_MHZ = 250;
  localparam int RST_MIN_SYSCLK = 12;
  localparam int RST_MIN_CYCLES = RST_MIN_SYSCLK;
  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // Standby states
  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_SLOW = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_STOP = 4'b1000
  } standby_state_t;
endpackage

// [rtl/clock_gear_standby_reset_control.sv]
// Notes on behaviour
// - Reset sets the clock gear to divide by eight.
// - Bypass strap sampled in reset; PLL multiplies oscillator by four.
// - Gear divides selected high clock by 2, 4 or 8.
// - Two-bit gear field in second control register picks the ratio.
// - Source bit picks gear output or, in dual-clock mode only, low-speed clock as system clock.
// - After reset the core fetches from the fixed shared reset vector.
// - Reset returns all control and status registers to defaults.
// - Reset puts every port pin in general-purpose mode.
// - Single-clock and dual-clock operation are both supported.
// - Leaving SLEEP resumes the state held before SLEEP.
// - State resumed after STOP comes from a first-register field.
// - In SLEEP only RTC, pulse counter and pull-up logic run.
// - Low-speed clock is 32.768 kHz; SLOW runs the core from it.
`timescale 1ns/100ps
module clock_gear_standby_reset_control
  import clock_gear_pkg::*;
#(
  parameter logic [31:0] BOOT_VECTOR = RESET_VECTOR
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ext_reset_n_i,
  input wire logic pll_bypass_strap_i,
  input wire logic low_speed_tick_i,
  input wire logic wake_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic sysclk_tick_o,
  output logic periph_tick_o,
  output logic keepalive_tick_o,
  output logic sub_osc_enable_o,
  output logic osc_input_divide_bit_o,
  output logic core_reset_o,
  output logic [31:0] boot_vector_o,
  output logic boot_vector_select_o,
  output logic periph_reset_o,
  output logic port_reset_o
);
  import clock_gear_pkg::*;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic stop_ret_slow;
    logic dual_clk;
    logic [1:0] gear_ratio_select;
    logic sysclk_source_select;
    logic osc_input_divide_bit;
    logic pll_on;
    logic [1:0] hi_cnt;
    logic [2:0] gear_cnt;
    logic [1:0] gear_act;
    logic src_act;
    standby_state_t state;
    standby_state_t pre_sleep;
    logic [31:0] rdata;
    logic sys_tick;
    logic per_tick;
    logic keep_tick;
    logic rst_out;
  } ctrl_t;

  logic rs1_q;
  logic rs2_q;
  logic ext_rst;
  ctrl_t q, d;
  ctrl_t reset_val;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  reset_pulse_filter #(
    .MIN_CYCLES(RST_MIN_CYCLES)
  ) u_filter (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rs2_q),
    .ext_reset_n_i(ext_reset_n_i),
    .reset_o(ext_rst)
  );

  always_comb begin
    reset_val.wr_pend = 1'b0;
    reset_val.wr_addr = 8'h00;
    reset_val.stop_ret_slow = 1'b0;
    reset_val.dual_clk = 1'b0;

    reset_val.gear_ratio_select = GEAR_RESET;
    reset_val.sysclk_source_select = 1'b0;
    reset_val.osc_input_divide_bit = 1'b0;
    reset_val.pll_on = 1'b1;
    reset_val.hi_cnt = 2'h0;
    reset_val.gear_cnt = 3'h0;
    reset_val.gear_act = GEAR_RESET;
    reset_val.src_act = 1'b0;
    reset_val.state = ST_NORMAL;
    reset_val.pre_sleep = ST_NORMAL;
    reset_val.rdata = 32'h0000_0000;
    reset_val.sys_tick = 1'b0;
    reset_val.per_tick = 1'b0;
    reset_val.keep_tick = 1'b0;
    reset_val.rst_out = 1'b1;
  end

  logic addr_ok;
  logic hi_tick;
  logic gear_tick;
  logic wrap;
  logic [2:0] gear_last;
  logic [1:0] cmd;
  logic running;
  logic src_tick;

  always_comb begin
    d = q;
    addr_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
    cmd = CMD_NONE;

    unique case (q.gear_act)
      GEAR_DIV2: gear_last = DIV2_LAST;
      GEAR_DIV4: gear_last = DIV4_LAST;
      default: gear_last = DIV8_LAST;
    endcase

    hi_tick = (q.state != ST_STOP) && (q.pll_on || (q.hi_cnt == PLL_LAST));
    if (q.state == ST_STOP) begin
      d.hi_cnt = 2'h0;
    end else begin
      d.hi_cnt = q.hi_cnt + 2'h1;
    end
    wrap = hi_tick && (q.gear_cnt == gear_last);
    gear_tick = wrap;
    if (wrap) begin
      d.gear_cnt = 3'h0;
    end else if (hi_tick) begin
      d.gear_cnt = q.gear_cnt + 3'h1;
    end

    if (wrap || q.state == ST_STOP) begin
      d.gear_act = q.gear_ratio_select;
      d.src_act = q.sysclk_source_select && q.dual_clk;
    end

    src_tick = q.src_act ? low_speed_tick_i : gear_tick;

    // Register writes in data phase
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        OFS_SYS_CTRL_FIRST: begin
          d.stop_ret_slow = hwdata_i[STOP_RET_BIT];
          d.dual_clk = hwdata_i[DUAL_CLK_BIT];
          cmd = hwdata_i[CMD_LSB +: 2];
        end
        OFS_SYS_CTRL_SECOND: begin
          d.gear_ratio_select = hwdata_i[GEAR_LSB +: 2];
          d.sysclk_source_select = hwdata_i[SYSCLK_SOURCE_SELECT_BIT];
          d.osc_input_divide_bit = hwdata_i[OSC_INPUT_DIVIDE_BIT_BIT];
        end
        default: begin
        end
      endcase
    end
    d.wr_pend = addr_ok && hwrite_i;
    if (addr_ok) begin
      d.wr_addr = {haddr_i[7:2], 2'b00};
    end

    // Standby state machine
    unique case (q.state)
      ST_NORMAL, ST_SLOW: begin
        if (q.src_act) begin
          d.state = ST_SLOW;
        end else begin
          d.state = ST_NORMAL;
        end
        if (cmd == CMD_SLEEP && q.dual_clk) begin
          d.pre_sleep = q.state;
          d.state = ST_SLEEP;
        end else if (cmd == CMD_STOP) begin
          d.state = ST_STOP;
        end
      end
      ST_SLEEP: begin
        if (wake_i) begin
          d.state = q.pre_sleep;
        end
      end
      ST_STOP: begin
        if (wake_i) begin
          d.sysclk_source_select = q.stop_ret_slow && q.dual_clk;
          d.src_act = q.stop_ret_slow && q.dual_clk;
          if (q.stop_ret_slow && q.dual_clk) begin
            d.state = ST_SLOW;
          end else begin
            d.state = ST_NORMAL;
          end
        end
      end
      default: d.state = ST_NORMAL;
    endcase

    running = (q.state == ST_NORMAL) || (q.state == ST_SLOW);
    d.sys_tick = running && src_tick;
    d.per_tick = running && src_tick;
    d.keep_tick = q.dual_clk && (q.state != ST_STOP) && low_speed_tick_i;

    // Read data registered for data phase
    d.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite_i) begin
      unique case ({haddr_i[7:2], 2'b00})
        OFS_SYS_CTRL_FIRST: begin
          d.rdata[STOP_RET_BIT] = q.stop_ret_slow;
          d.rdata[DUAL_CLK_BIT] = q.dual_clk;
        end
        OFS_SYS_CTRL_SECOND: begin
          d.rdata[GEAR_LSB +: 2] = q.gear_ratio_select;
          d.rdata[SYSCLK_SOURCE_SELECT_BIT] = q.sysclk_source_select;
          d.rdata[OSC_INPUT_DIVIDE_BIT_BIT] = q.osc_input_divide_bit;
        end
        OFS_STATUS: begin
          d.rdata[3:0] = q.state;
          d.rdata[4] = q.pll_on;
          d.rdata[6:5] = q.gear_act;
          d.rdata[7] = q.src_act;
        end
        default: begin
        end
      endcase
    end
    d.rst_out = 1'b0;

    if (ext_rst) begin
      d = reset_val;
    end

    if (ext_rst || q.rst_out) begin
      d.pll_on = pll_bypass_strap_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rs2_q) begin
    if (!rs2_q) begin
      q <= '{
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        stop_ret_slow: 1'b0,
        dual_clk: 1'b0,
        gear_ratio_select: GEAR_RESET,
        sysclk_source_select: 1'b0,
        osc_input_divide_bit: 1'b0,
        pll_on: 1'b1,
        hi_cnt: 2'h0,
        gear_cnt: 3'h0,
        gear_act: GEAR_RESET,
        src_act: 1'b0,
        state: ST_NORMAL,
        pre_sleep: ST_NORMAL,
        rdata: 32'h0000_0000,
        sys_tick: 1'b0,
        per_tick: 1'b0,
        keep_tick: 1'b0,
        rst_out: 1'b1
      };
    end else begin
      q <= d;
    end
  end

  logic hready_q;
  logic hresp_q;
  logic [31:0] vec_q;
  logic bev_q;
  always_ff @(posedge clk_sys_i or negedge rs2_q) begin
    if (!rs2_q) begin
      hready_q <= 1'b0;
      hresp_q <= HRESP_OKAY;
      vec_q <= 32'h0000_0000;
      bev_q <= 1'b0;
    end else begin
      hready_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
      vec_q <= BOOT_VECTOR;
      bev_q <= 1'b1;
    end
  end

  assign hrdata_o = q.rdata;
  assign hreadyout_o = hready_q;
  assign hresp_o = hresp_q;
  assign sysclk_tick_o = q.sys_tick;
  assign periph_tick_o = q.per_tick;
  assign keepalive_tick_o = q.keep_tick;
  assign sub_osc_enable_o = q.dual_clk;
  assign osc_input_divide_bit_o = q.osc_input_divide_bit;
  assign core_reset_o = q.rst_out;
  assign boot_vector_o = vec_q;
  assign boot_vector_select_o = bev_q;
  assign periph_reset_o = q.rst_out;
  assign port_reset_o = q.rst_out;
endmodule

// [rtl/reset_pulse_filter.sv]
`timescale 1ns/100ps
module reset_pulse_filter
  import clock_gear_pkg::*;
#(
  parameter int MIN_CYCLES = RST_MIN_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ext_reset_n_i,
  output logic reset_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [7:0] cnt;
    logic rst;
  } filt_t;
  filt_t q, d;
  always_comb begin
    d = q;
    d.s1 = ext_reset_n_i;
    d.s2 = q.s1;
    if (q.s2) begin
      d.cnt = 8'h00;
      d.rst = 1'b0;
    end else if (q.cnt < 8'(MIN_CYCLES - 1)) begin
      d.cnt = q.cnt + 8'h01;
    end else begin
      d.rst = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, rst: 1'b0};
    end else begin
      q <= d;
    end
  end
  assign reset_o = q.rst;
endmodule

// [tb/clock_gear_chk.sv]
`timescale 1ns/100ps
module clock_gear_chk
  import clock_gear_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ext_reset_n_i,
  input wire logic low_speed_tick_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic sysclk_tick_o,
  input wire logic periph_tick_o,
  input wire logic keepalive_tick_o,
  input wire logic sub_osc_enable_o,
  input wire logic osc_input_divide_bit_o,
  input wire logic core_reset_o,
  input wire logic [31:0] boot_vector_o,
  input wire logic boot_vector_select_o,
  input wire logic periph_reset_o,
  input wire logic port_reset_o
);
  logic rd_q;
  logic [4:0] low_q;
  logic [4:0] run_q;
  // Read data phase and pin low-run length
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_q <= 1'b0;
      low_q <= 5'h00;
      run_q <= 5'h00;
    end else begin
      rd_q <= hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i;
      low_q <= ext_reset_n_i ? 5'h00 : low_q + {4'h0, low_q != 5'h1F};
      if (ext_reset_n_i && low_q != 5'h00) begin
        run_q <= low_q;
      end
    end
  end
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  sequence long_low_s;
    !ext_reset_n_i [*8] ##1 !ext_reset_n_i [*8];
  endsequence
  sequence boot_ok_s;
    boot_vector_o == RESET_VECTOR && boot_vector_select_o;
  endsequence
  sequence long_run_s;
    low_q >= 5'h0C || run_q >= 5'h0C;
  endsequence
  sequence regs_clear_s;
    !sub_osc_enable_o && !osc_input_divide_bit_o;
  endsequence
  resp_okay_a: assert property (hresp_o == HRESP_OKAY)
    else $error("bad response");
  rd_idle_a: assert property (!rd_q |-> hrdata_o == 32'h0)
    else $error("read data outside data phase");
  bus_ready_a: assert property (!core_reset_o |-> hreadyout_o)
    else $error("bus not ready");
  reset_outs_a: assert property ({periph_reset_o, port_reset_o} == {2{core_reset_o}})
    else $error("reset outputs differ");
  boot_vec_a: assert property ($fell(core_reset_o) |=> boot_ok_s)
    else $error("boot vector wrong");
  filt_short_a: assert property ($rose(core_reset_o) |-> long_run_s)
    else $error("short pulse reset");
  filt_long_a: assert property (long_low_s |-> ##[0:6] core_reset_o)
    else $error("long pulse ignored");
  tick_space_a: assert property (sysclk_tick_o |=> !sysclk_tick_o)
    else $error("ticks too close");
  periph_same_a: assert property (periph_tick_o == sysclk_tick_o)
    else $error("peripheral tick differs");
  keep_src_a: assert property (keepalive_tick_o |-> $past(low_speed_tick_i))
    else $error("keepalive without low tick");
  reset_regs_a: assert property (core_reset_o [*3] |-> regs_clear_s)
    else $error("control bits not reset");
endmodule
bind clock_gear_standby_reset_control clock_gear_chk u_clock_gear_chk (.*);

// [tb/clock_gear_standby_reset_control_tb.sv]
`timescale 1ns/100ps
module clock_gear_standby_reset_control_tb;
  import clock_gear_pkg::*;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, boot_vector_o, r;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic ext_reset_n_i, pll_bypass_strap_i, low_speed_tick_i, wake_i, hreadyout_o, hresp_o;
  logic sysclk_tick_o, periph_tick_o, keepalive_tick_o, sub_osc_enable_o, osc_input_divide_bit_o;
  logic core_reset_o, boot_vector_select_o, periph_reset_o, port_reset_o;
  wire hready_i = hreadyout_o;
  int miscompares = 0, n_tests = 0, p, s, k;
  clock_gear_standby_reset_control u_clock_gear_standby_reset_control (.*);
  osc_reset_source u_osc_reset_source (
    .clk_sys_i(clk_sys_i),
    .ext_reset_n_o(ext_reset_n_i),
    .strap_o(pll_bypass_strap_i),
    .low_speed_tick_o(low_speed_tick_i),
    .wake_o(wake_i)
  );
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task automatic complete_run();
    $display("n_tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 64);
    if (hreadyout_o !== 1'b1) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= HTRANS_NONSEQ;
    edge_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    edge_rdy();
    r = hrdata_o;
  endtask
  task automatic tick_gap(output int g);
    int n;
    n = 0;
    do @(posedge clk_sys_i); while (sysclk_tick_o !== 1'b1 && ++n < 600);
    g = 0;
    do @(posedge clk_sys_i); while (sysclk_tick_o !== 1'b1 && ++g < 600);
    if (n >= 600 || g >= 600) begin
      miscompares++;
      complete_run();
    end
    g++;
  endtask
  task automatic count_ticks();
    s = 0;
    k = 0;
    @(posedge clk_sys_i);
    repeat (200) begin
      @(posedge clk_sys_i);
      s += (sysclk_tick_o === 1'b1);
      k += (keepalive_tick_o === 1'b1);
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk({core_reset_o, periph_reset_o, port_reset_o}, 32'h0);
    chk(boot_vector_o, RESET_VECTOR);
    chk(boot_vector_select_o, 32'h1);
    bus(1'b0, OFS_SYS_CTRL_SECOND, 32'h0);
    chk(r, {30'h0, GEAR_RESET});
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(r, {24'h0, 1'b0, GEAR_DIV8, 1'b1, ST_NORMAL});
    bus(1'b0, 8'h0C, 32'h0);
    chk(r, 32'h0);
    tick_gap(p);
    chk(p, 32'h8);
    for (int g = 0; g < 4; g++) begin
      bus(1'b1, OFS_SYS_CTRL_SECOND, g);
      tick_gap(p);
      tick_gap(p);
      chk(p, g == 3 ? 8 : 2 << g);
    end
    bus(1'b1, OFS_SYS_CTRL_SECOND, 32'h0A);
    repeat (2) @(posedge clk_sys_i);
    chk(osc_input_divide_bit_o, 32'h1);
    bus(1'b1, OFS_SYS_CTRL_FIRST, 32'h10);
    bus(1'b1, OFS_SYS_CTRL_SECOND, 32'h04);
    chk(sub_osc_enable_o, 32'h1);
    tick_gap(p);
    tick_gap(p);
    chk(p, 32'd40);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(r, {24'h0, 1'b1, GEAR_DIV2, 1'b1, ST_SLOW});
    bus(1'b1, OFS_SYS_CTRL_FIRST, {27'h0, 1'b1, CMD_SLEEP, 2'h0});
    count_ticks();
    chk({s == 0, k > 2}, 32'h3);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(r[3:0], ST_SLEEP);
    u_osc_reset_source.wake_pulse();
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(r[3:0], ST_SLOW);
    for (int t = 0; t < 2; t++) begin
      bus(1'b1, OFS_SYS_CTRL_FIRST, {27'h0, 1'b1, CMD_STOP, 1'b0, t == 1});
      count_ticks();
      chk({s[15:0], k[15:0]}, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[3:0], ST_STOP);
      u_osc_reset_source.wake_pulse();
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[3:0], t == 1 ? ST_SLOW : ST_NORMAL);
    end
    u_osc_reset_source.pin_reset(8, 1'b1);
    repeat (20) @(posedge clk_sys_i);
    chk({core_reset_o, sub_osc_enable_o}, 32'h1);
    u_osc_reset_source.pin_reset(20, 1'b0);
    chk(core_reset_o, 32'h1);
    repeat (8) @(posedge clk_sys_i);
    chk({core_reset_o, sub_osc_enable_o}, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(r, {24'h0, 1'b0, GEAR_DIV8, 1'b0, ST_NORMAL});
    tick_gap(p);
    tick_gap(p);
    chk(p, 8 * (PLL_LAST + 1));
    complete_run();
  end
endmodule

// [tb/osc_reset_source.sv]
`timescale 1ns/100ps
module osc_reset_source #(
  parameter int LS_PERIOD = 40
) (
  input wire logic clk_sys_i,
  output logic ext_reset_n_o,
  output logic strap_o,
  output logic low_speed_tick_o,
  output logic wake_o
);
  int cnt = 0;
  initial begin
    ext_reset_n_o = 1'b1;
    strap_o = 1'b1;
    low_speed_tick_o = 1'b0;
    wake_o = 1'b0;
  end
  always @(posedge clk_sys_i) begin
    cnt <= (cnt == LS_PERIOD - 1) ? 0 : cnt + 1;
    low_speed_tick_o <= (cnt == LS_PERIOD - 1);
  end
  task automatic pin_reset(input int n, input logic strap);
    ext_reset_n_o <= 1'b0;
    strap_o <= strap;
    repeat (n) @(posedge clk_sys_i);
    ext_reset_n_o <= 1'b1;
  endtask
  task automatic wake_pulse();
    wake_o <= 1'b1;
    @(posedge clk_sys_i);
    wake_o <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule
